// file: lsl_defines.vh
// Constants for the LED sink shift and latch block
`ifndef LSL_DEFINES_VH
`define LSL_DEFINES_VH
`define LSL_WIDTH        16
`define LSL_CLK_NS       20
`define LSL_STAGGER_NS   17
`define LSL_STAGGER_CYC  ((`LSL_STAGGER_NS + `LSL_CLK_NS - 1) / `LSL_CLK_NS)
`define LSL_CNT_W        5
`define LSL_LAST_CH      5'h0f
`define LSL_SHIFT_RST    16'h0000
`define LSL_LATCH_RST    16'h0000
`endif

// file: lsl_sync.v
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
`include "lsl_defines.vh"
module lsl_sync #(
  parameter [0:0] RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire clock,
  input  wire nrst,
  input  wire clk_en,
  // Pin and synchronised level
  input  wire pin_in,
  output wire sync_out
);
  reg meta_ff;
  reg sync_ff;

  // Two flip-flops, second one read only
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else if (clk_en) begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule // lsl_sync

// file: lsl_stagger.v
// Staggered per-channel sink update sequencer
`timescale 1ns/100ps
`include "lsl_defines.vh"
module lsl_stagger (
  // Clock and reset
  input  wire        clock,
  input  wire        nrst,
  input  wire        clk_en,
  // Control
  input  wire        start,
  input  wire [15:0] target,
  input  wire        disable_all,
  // Sink drive
  output wire [15:0] sink_channels
);
  reg [15:0]          drive_ff;
  reg [`LSL_CNT_W-1:0] ch_ff;
  reg [`LSL_CNT_W-1:0] gap_ff;
  reg                 run_ff;
  wire [15:0]         onehot;
  reg [15:0]          sink_ff;
  wire [31:0]         gap_load;

  // Gap reload: stagger cycles less one, cut to the counter width
  assign gap_load = `LSL_STAGGER_CYC - 1;

  genvar g;
  generate
    for (g = 0; g < `LSL_WIDTH; g = g + 1) begin : g_sel
      assign onehot[g] = ({{(32 - `LSL_CNT_W){1'b0}}, ch_ff} == g);
    end
  endgenerate

  // R9 step per channel: one channel follows the next after a gap
  // R10 sequence start: a strobe restarts from the first channel
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      drive_ff <= `LSL_LATCH_RST;
      ch_ff    <= {`LSL_CNT_W{1'b0}};
      gap_ff   <= {`LSL_CNT_W{1'b0}};
      run_ff   <= 1'b0;
    end else if (clk_en) begin
      if (start) begin
        run_ff <= 1'b1;
        ch_ff  <= {`LSL_CNT_W{1'b0}};
        gap_ff <= {`LSL_CNT_W{1'b0}};
      end else if (run_ff) begin
        if (gap_ff == 5'h00) begin
          drive_ff <= (drive_ff & ~onehot) | (target & onehot);
          gap_ff   <= gap_load[`LSL_CNT_W-1:0];
          if (ch_ff == `LSL_LAST_CH)
            run_ff <= 1'b0;
          else
            ch_ff <= ch_ff + 5'h01;
        end else begin
          gap_ff <= gap_ff - 5'h01;
        end
      end
    end
  end

  // R7 blank all: disable gates drive, latch untouched
  // R13 one enables: a set bit turns its sink on
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sink_ff <= `LSL_LATCH_RST;
    end else if (clk_en) begin
      sink_ff <= disable_all ? 16'h0000 : drive_ff;
    end
  end

  // Sinks leave straight from a flip-flop
  assign sink_channels = sink_ff;
endmodule // lsl_stagger

// file: lsl_top.v
// LED sink driver serial shift register, transfer latch and blanking
`timescale 1ns/100ps
`include "lsl_defines.vh"

// How it works
// R1 - Each serial clock rising edge shifts serial_in into the 16-bit register.
// R2 - The last shift stage drives serial_out for the next device.
// R3 - System chains serial_out to next serial_in on a shared serial clock.
// R4 - Strobe rise loads latch; latch follows shift register while strobe high.
// R5 - Strobe fall freezes latch until the strobe rises again.
// R6 - Disable low: each sink follows its latch bit.
// R7 - Disable high: all sinks off, latch contents kept.
// R8 - Reset clears shift register and latch and turns all sinks off.
// R9 - Successive channels switch one stagger step apart.
// R10 - Stagger starts at strobe, for both turn-on and turn-off.
// R11 - Host keeps 800 ns between strobe and neighbouring serial clock edge.
// R12 - Undriven disable reads active and undriven strobe reads low.
// R13 - Latch one enables sink; first bit reaches serial_out after 16 edges.
module lsl_top (
  // Clock, reset and enable
  input  wire        clock,
  input  wire        nrst,
  input  wire        clk_en,
  // Host pins
  input  wire        serial_clk,
  input  wire        serial_in,
  input  wire        strobe,
  input  wire        strobe_driven,
  input  wire        out_disable,
  input  wire        disable_driven,
  // Device outputs
  output wire        serial_out,
  output wire [15:0] sink_channels
);
  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  wire sclk_s;
  wire sdat_s;
  wire stb_s;
  wire dis_s;
  wire stb_pin;
  wire dis_pin;

  // R12 pin defaults: pull-down strobe, pull-up disable
  assign stb_pin = strobe_driven & strobe;
  assign dis_pin = ~disable_driven | out_disable;

  lsl_sync #(.RST_VAL(1'b0)) u_sclk (
    .clock    (clock),
    .nrst     (nrst),
    .clk_en   (clk_en),
    .pin_in   (serial_clk),
    .sync_out (sclk_s)
  );
  lsl_sync #(.RST_VAL(1'b0)) u_sdat (
    .clock    (clock),
    .nrst     (nrst),
    .clk_en   (clk_en),
    .pin_in   (serial_in),
    .sync_out (sdat_s)
  );
  lsl_sync #(.RST_VAL(1'b0)) u_stb (
    .clock    (clock),
    .nrst     (nrst),
    .clk_en   (clk_en),
    .pin_in   (stb_pin),
    .sync_out (stb_s)
  );
  lsl_sync #(.RST_VAL(1'b1)) u_dis (
    .clock    (clock),
    .nrst     (nrst),
    .clk_en   (clk_en),
    .pin_in   (dis_pin),
    .sync_out (dis_s)
  );

  // ************************************************************
  // Shift register and latch
  // ************************************************************
  reg  [15:0] shift_ff;
  reg  [15:0] latch_ff;
  reg         sclk_d_ff;
  reg         stb_d_ff;
  wire        sclk_rise;
  wire        stb_rise;

  // Edge detectors on synchronised levels
  assign sclk_rise = sclk_s & ~sclk_d_ff;
  assign stb_rise  = stb_s & ~stb_d_ff;

  // Next shift register value, shared by the shift and the open latch
  function [15:0] shift_next;
    input [15:0] cur;
    input        bit_in;
    begin
      shift_next = {cur[14:0], bit_in};
    end
  endfunction

  // R8 reset clear: everything cleared, sinks off
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      shift_ff  <= `LSL_SHIFT_RST;
      latch_ff  <= `LSL_LATCH_RST;
      sclk_d_ff <= 1'b0;
      stb_d_ff  <= 1'b0;
    end else if (clk_en) begin
      sclk_d_ff <= sclk_s;
      stb_d_ff  <= stb_s;
      // R1 serial shift: bit enters stage zero
      // R13 sixteen edges: first bit reaches stage fifteen
      if (sclk_rise)
        shift_ff <= shift_next(shift_ff, sdat_s);
      // R4 latch follows: transparent while strobe high
      // R5 latch holds: strobe low keeps value
      if (stb_s)
        latch_ff <= sclk_rise ? shift_next(shift_ff, sdat_s) : shift_ff;
    end
  end

  // R2 chain output: last stage drives serial_out
  assign serial_out = shift_ff[15];

  // ************************************************************
  // Staggered sink drive
  // ************************************************************
  wire walk_start;

  // R10 walk start: strobe rise, or a shift while the latch is open
  assign walk_start = stb_rise | (stb_s & sclk_rise);

  // R6 sinks follow latch through the staggered walk
  lsl_stagger u_stag (
    .clock         (clock),
    .nrst          (nrst),
    .clk_en        (clk_en),
    .start         (walk_start),
    .target        (stb_s ? shift_ff : latch_ff),
    .disable_all   (dis_s),
    .sink_channels (sink_channels)
  );
endmodule // lsl_top

// file: lsl_monitor.sv
// Pin-level checks for the LED sink shift and latch block
`timescale 1ns/100ps
module lsl_monitor (
  // Clock and reset
  input wire        clock,
  input wire        nrst,
  // Pins
  input wire        serial_clk,
  input wire        strobe,
  input wire        strobe_driven,
  input wire        out_disable,
  input wire        disable_driven,
  input wire        serial_out,
  input wire [15:0] sink_channels
);
  // Effective disable, undriven reads active
  wire dis = out_disable | ~disable_driven;
  logic [4:0] quiet_ff;
  logic       dis_ff;
  // Cycles since the last strobe or disable change
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      quiet_ff <= 5'h1f;
      dis_ff   <= 1'b1;
    end else begin
      dis_ff   <= dis;
      quiet_ff <= ((strobe & strobe_driven) | (dis ^ dis_ff)) ? 5'h00 :
                  quiet_ff + {4'h0, quiet_ff != 5'h1f};
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  chk_rst_clear: assert property ($rose(nrst) |-> sink_channels == 16'h0000 && !serial_out)
    else $error("outputs not clear after reset");
  chk_dis_blank: assert property (dis [*4] |-> sink_channels == 16'h0000)
    else $error("sinks on while disabled");
  chk_undriven_off: assert property (!disable_driven [*4] |-> sink_channels == 16'h0000)
    else $error("sinks on with disable undriven");
  chk_serial_out_timing: assert property ($changed(serial_out) |->
    $past(serial_clk, 2) || $past(serial_clk, 3) || $past(serial_clk, 4))
    else $error("serial out moved without serial clock");
  chk_serial_out_hold: assert property (!serial_clk [*6] |-> $stable(serial_out))
    else $error("serial out moved while clock idle");
  chk_sink_window: assert property ($changed(sink_channels) |-> quiet_ff <= 5'h16)
    else $error("sinks moved long after strobe");
  chk_one_step: assert property ((!dis) [*5] ##0 $changed(sink_channels) |->
    $onehot(sink_channels ^ $past(sink_channels)))
    else $error("several channels switched in one step");
  chk_stagger_start: assert property ($rose(strobe & strobe_driven) |=>
    $stable(sink_channels) [*2])
    else $error("sinks switched at strobe edge");
  cov_strobe: cover property ($rose(strobe & strobe_driven));
  cov_blank: cover property ($rose(out_disable));
  cov_serial_out: cover property ($rose(serial_out));
endmodule // lsl_monitor
bind lsl_top lsl_monitor mon (.clock(clock), .nrst(nrst), .serial_clk(serial_clk),
  .strobe(strobe), .strobe_driven(strobe_driven), .out_disable(out_disable),
  .disable_driven(disable_driven), .serial_out(serial_out), .sink_channels(sink_channels));

// file: lsl_host.sv
// Host controller model for the serial pins
`timescale 1ns/100ps
module lsl_host (
  // Clock
  input  wire  clock,
  // Host pins
  output logic serial_clk,
  output logic serial_in,
  output logic strobe
);
  initial begin
    serial_clk = 1'b0;
    serial_in  = 1'b0;
    strobe     = 1'b0;
  end
  // one bit per serial clock, idle low
  task automatic put_bit(input logic b);
    @(negedge clock) serial_in = b;
    repeat (4) @(negedge clock);
    serial_clk = 1'b1;
    repeat (4) @(negedge clock);
    serial_clk = 1'b0;
  endtask
  // strobe kept 800 ns from serial clock edges
  task automatic pulse;
    repeat (40) @(negedge clock);
    strobe = 1'b1;
    repeat (4) @(negedge clock);
    strobe = 1'b0;
    repeat (40) @(negedge clock);
  endtask
  // strobe level set 800 ns clear of serial clock edges
  task automatic set_strobe(input logic lvl);
    repeat (40) @(negedge clock);
    strobe = lvl;
    repeat (40) @(negedge clock);
  endtask
endmodule // lsl_host

// file: tb.sv
// Self-checking testbench for the LED sink shift and latch block
`timescale 1ns/100ps
module tb;
  logic        clock, nrst, strobe_driven, out_disable, disable_driven;
  wire         serial_clk, serial_in, strobe, serial_out;
  wire  [15:0] sink_channels;
  logic [15:0] prev, word;
  int          failures, checked, cycles;
  lsl_host host (.clock(clock), .serial_clk(serial_clk), .serial_in(serial_in), .strobe(strobe));
  lsl_top dut (.clock(clock), .nrst(nrst), .clk_en(1'b1), .serial_clk(serial_clk),
    .serial_in(serial_in), .strobe(strobe), .strobe_driven(strobe_driven),
    .out_disable(out_disable), .disable_driven(disable_driven), .serial_out(serial_out),
    .sink_channels(sink_channels));
  // Expected sinks from latch and disable
  function automatic logic [15:0] exp_sink(input logic [15:0] l, input logic d);
    return d ? 16'h0000 : l;
  endfunction
  // Expected serial_out after bit i of w, with p shifted in before
  function automatic logic exp_serial_out(input logic [15:0] p, input logic [15:0] w, input int i);
    logic [31:0] both;
    both = {p, w};
    return both[30 - i];
  endfunction
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out;
    if (failures == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      close_out();
    end
  end
  initial begin
    nrst = 1'b0;
    strobe_driven = 1'b1;
    out_disable = 1'b0;
    disable_driven = 1'b1;
    prev = 16'h0000;
    void'($urandom(80));
    repeat (16) @(negedge clock);
    check("rst", 16'h0000, sink_channels);
    nrst = 1'b1;
    for (int n = 0; n < 8; n++) begin
      word = n == 0 ? 16'hffff : n == 1 ? 16'h0000 : n == 2 ? 16'h8001 : 16'($urandom);
      if (n == 3) host.set_strobe(1'b1);
      for (int i = 0; i < 16; i++) begin
        host.put_bit(word[15 - i]);
        check("serial_out", {15'h0000, exp_serial_out(prev, word, i)}, {15'h0000, serial_out});
      end
      if (n == 3) begin
        host.set_strobe(1'b0);
      end else begin
        check("held", prev, sink_channels);
        host.pulse();
      end
      check("on", word, sink_channels);
      out_disable = 1'b1;
      repeat (5) @(negedge clock);
      check("blank", exp_sink(word, 1'b1), sink_channels);
      out_disable = 1'b0;
      repeat (5) @(negedge clock);
      check("kept", exp_sink(word, 1'b0), sink_channels);
      prev = word;
    end
    word = 16'($urandom) | 16'h8000;
    for (int i = 0; i < 16; i++) host.put_bit(word[15 - i]);
    check("serial_out top", 16'h0001, {15'h0000, serial_out});
    strobe_driven = 1'b0;
    host.pulse();
    check("ustb", prev, sink_channels);
    disable_driven = 1'b0;
    repeat (5) @(negedge clock);
    check("udis", 16'h0000, sink_channels);
    disable_driven = 1'b1;
    repeat (5) @(negedge clock);
    check("unblank", exp_sink(prev, 1'b0), sink_channels);
    nrst = 1'b0;
    repeat (2) @(negedge clock);
    check("rst sinks", 16'h0000, sink_channels);
    check("rst serial_out", 16'h0000, {15'h0000, serial_out});
    nrst = 1'b1;
    repeat (5) @(negedge clock);
    check("rst kept", 16'h0000, sink_channels);
    close_out();
  end
endmodule // tb
